// >>> logic/lsgd_ctrl.v
// lamp switch, aux 5v output and dimming glass control register bank
// Operation
// - lamp over-current turns switch off, sets flag
// - pwm rising edge re-enables after over-current trip
// - limiting on-time ends on over-current, not pwm
// - aux output needs power-stage and own bit
// - voltage flags never touch aux output
// - aux current limit sets flag, stays on
// - force-on bits read/write, reset cleared
// - pwm-select bits follow pwm, reset cleared
// - write one clears lamp flag, re-enables
// - write one clears aux flag
// - open-load test sources current, sets flag
// - open-load test disables glass driving
// - glass short sets flag, disables glass
// - write one clears short flag, re-enables
// - write one clears open-load flag, disables glass
// - six-bit glass code, upper bits zero
// - regulator transistor enable bit
// - series switch transistor enable bit
// - power-stage bit gates power outputs
// - stop/sleep set by write, cleared by irq
// - stop only when bits 7..2 written zero
// - sleep only when bits 7..2 zero
// - lamps off while power-stage bit clear
// - force plus pwm: flag set, output kept
`timescale 1ns/1ns
`default_nettype none
`include "lsgd_consts.vh"

module lsgd_ctrl #(
   parameter NUM_SWITCHES = 3
)(
   input wire clk_in,
   input wire resetn_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output reg [7:0] reg_rdata_out,
   input wire pwm_in,
   input wire cpu_irq_in,
   input wire [NUM_SWITCHES-1:0] lamp_overcurrent_in,
   input wire aux_overcurrent_in,
   input wire glass_short_in,
   input wire glass_openload_cmp_in,
   output reg [NUM_SWITCHES-1:0] lamp_switch_on_out,
   output reg aux_5v_output_on_out,
   output reg power_stage_enable_out,
   output reg glass_regulator_enable_out,
   output reg glass_series_switch_enable_out,
   output reg glass_test_current_out,
   output reg [`LSGD_CODE_WIDTH-1:0] glass_voltage_code_out,
   output reg stop_request_out,
   output reg sleep_request_out
);

   // register state
   reg power_stage_enable_reg;
   reg stop_reg;
   reg sleep_reg;
   reg [NUM_SWITCHES-1:0] lamp_switch_force_on_reg;
   reg [NUM_SWITCHES-1:0] lamp_switch_pwm_select_reg;
   reg aux_5v_out_on_reg;
   reg [NUM_SWITCHES-1:0] lamp_switch_overcurrent_flag_reg;
   reg aux_5v_overcurrent_flag_reg;
   reg glass_regulator_enable_reg;
   reg glass_openload_test_reg;
   reg glass_series_switch_enable_reg;
   reg glass_short_flag_reg;
   reg glass_openload_flag_reg;
   reg [`LSGD_CODE_WIDTH-1:0] glass_voltage_code_bits_reg;
   reg [NUM_SWITCHES-1:0] limit_on_reg;
   reg pwm_prev_reg;

   wire pwm_rise;
   wire wr_sys;
   wire wr_hso;
   wire wr_hsf;
   wire wr_gc;
   wire wr_code;
   wire mode_ok;
   wire [NUM_SWITCHES-1:0] lamp_clear;
   wire aux_clear;
   wire short_clear;
   wire olf_clear;
   wire olf_event;
   wire glass_allowed;

   reg [NUM_SWITCHES-1:0] lamp_on_next;
   reg [7:0] rdata_next;
   integer i;

   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = reg_write_in && (addr == target);
      end
   endfunction

   assign pwm_rise = pwm_in & ~pwm_prev_reg;
   assign wr_sys = hit(reg_addr_in, `LSGD_ADDR_SYSTEM_CONTROL);
   assign wr_hso = hit(reg_addr_in, `LSGD_ADDR_HS_OUT_CTRL);
   assign wr_hsf = hit(reg_addr_in, `LSGD_ADDR_HS_FAULT);
   assign wr_gc = hit(reg_addr_in, `LSGD_ADDR_GLASS_CTRL);
   assign wr_code = hit(reg_addr_in, `LSGD_ADDR_GLASS_CODE);
   // mode changes are safe only with bits 7..2 zero
   assign mode_ok = (reg_wdata_in[7:2] == 6'h00);

   assign lamp_clear = wr_hsf ? reg_wdata_in[`LSGD_HSF_OCF_LSB +: NUM_SWITCHES]
                              : {NUM_SWITCHES{1'b0}};
   assign aux_clear = wr_hsf & reg_wdata_in[`LSGD_HSF_AUX_OCF_BIT];
   assign short_clear = wr_gc & reg_wdata_in[`LSGD_GC_SHORT_BIT];
   assign olf_clear = wr_gc & reg_wdata_in[`LSGD_GC_OLF_BIT];
   assign olf_event = glass_openload_test_reg & glass_openload_cmp_in;
   // test mode and a latched short both hold the glass drive off
   assign glass_allowed = ~glass_openload_test_reg & ~glass_short_flag_reg;

   // lamp drive decision per switch
   always @*
   begin
      lamp_on_next = {NUM_SWITCHES{1'b0}};
      for (i = 0; i < NUM_SWITCHES; i = i + 1)
      begin
         if (!power_stage_enable_reg)
            lamp_on_next[i] = 1'b0;
         else if (lamp_switch_force_on_reg[i] && lamp_switch_pwm_select_reg[i])
            lamp_on_next[i] = 1'b1;
         else if (lamp_switch_force_on_reg[i])
            lamp_on_next[i] = ~lamp_switch_overcurrent_flag_reg[i] &
                              ~lamp_overcurrent_in[i];
         else if (lamp_switch_pwm_select_reg[i])
         begin
            // once tripped, pwm duty no longer ends the on-time
            if (lamp_switch_overcurrent_flag_reg[i] || lamp_overcurrent_in[i])
               lamp_on_next[i] = (limit_on_reg[i] | pwm_rise) &
                                 ~lamp_overcurrent_in[i];
            else
               lamp_on_next[i] = pwm_in;
         end
         else
            lamp_on_next[i] = 1'b0;
      end
   end

   // registered read data, unmapped reads give zero
   always @*
   begin
      rdata_next = 8'h00;
      case (reg_addr_in)
         `LSGD_ADDR_SYSTEM_CONTROL:
         begin
            rdata_next[`LSGD_SYS_POWER_STAGE_ENABLE_BIT] = power_stage_enable_reg;
            rdata_next[`LSGD_SYS_STOP_BIT] = stop_reg;
            rdata_next[`LSGD_SYS_SLEEP_BIT] = sleep_reg;
         end
         `LSGD_ADDR_HS_OUT_CTRL:
         begin
            rdata_next[`LSGD_HSO_ON_LSB +: NUM_SWITCHES] = lamp_switch_force_on_reg;
            rdata_next[`LSGD_HSO_PWM_LSB +: NUM_SWITCHES] = lamp_switch_pwm_select_reg;
            rdata_next[`LSGD_HSO_AUX_ON_BIT] = aux_5v_out_on_reg;
         end
         `LSGD_ADDR_HS_FAULT:
         begin
            rdata_next[`LSGD_HSF_OCF_LSB +: NUM_SWITCHES] = lamp_switch_overcurrent_flag_reg;
            rdata_next[`LSGD_HSF_AUX_OCF_BIT] = aux_5v_overcurrent_flag_reg;
         end
         `LSGD_ADDR_GLASS_CTRL:
         begin
            rdata_next[`LSGD_GC_REG_EN_BIT] = glass_regulator_enable_reg;
            rdata_next[`LSGD_GC_OLT_BIT] = glass_openload_test_reg;
            rdata_next[`LSGD_GC_SER_EN_BIT] = glass_series_switch_enable_reg;
            rdata_next[`LSGD_GC_SHORT_BIT] = glass_short_flag_reg;
            rdata_next[`LSGD_GC_OLF_BIT] = glass_openload_flag_reg;
         end
         `LSGD_ADDR_GLASS_CODE:
            rdata_next[`LSGD_CODE_WIDTH-1:0] = glass_voltage_code_bits_reg;
         default:
            rdata_next = 8'h00;
      endcase
   end

   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         power_stage_enable_reg <= 1'b0;
         stop_reg <= 1'b0;
         sleep_reg <= 1'b0;
         lamp_switch_force_on_reg <= {NUM_SWITCHES{1'b0}};
         lamp_switch_pwm_select_reg <= {NUM_SWITCHES{1'b0}};
         aux_5v_out_on_reg <= 1'b0;
         lamp_switch_overcurrent_flag_reg <= {NUM_SWITCHES{1'b0}};
         aux_5v_overcurrent_flag_reg <= 1'b0;
         glass_regulator_enable_reg <= 1'b0;
         glass_openload_test_reg <= 1'b0;
         glass_series_switch_enable_reg <= 1'b0;
         glass_short_flag_reg <= 1'b0;
         glass_openload_flag_reg <= 1'b0;
         glass_voltage_code_bits_reg <= {`LSGD_CODE_WIDTH{1'b0}};
         limit_on_reg <= {NUM_SWITCHES{1'b0}};
         pwm_prev_reg <= 1'b0;
         reg_rdata_out <= `LSGD_RESET_BYTE;
         lamp_switch_on_out <= {NUM_SWITCHES{1'b0}};
         aux_5v_output_on_out <= 1'b0;
         power_stage_enable_out <= 1'b0;
         glass_regulator_enable_out <= 1'b0;
         glass_series_switch_enable_out <= 1'b0;
         glass_test_current_out <= 1'b0;
         glass_voltage_code_out <= {`LSGD_CODE_WIDTH{1'b0}};
         stop_request_out <= 1'b0;
         sleep_request_out <= 1'b0;
      end
      else
      begin
         pwm_prev_reg <= pwm_in;
         limit_on_reg <= lamp_on_next;
         if (reg_read_in)
            reg_rdata_out <= rdata_next;

         if (wr_sys)
            power_stage_enable_reg <= reg_wdata_in[`LSGD_SYS_POWER_STAGE_ENABLE_BIT];
         // write-set beats an irq clear in the same cycle
         if (wr_sys && mode_ok && reg_wdata_in[`LSGD_SYS_STOP_BIT])
            stop_reg <= 1'b1;
         else if (cpu_irq_in)
            stop_reg <= 1'b0;
         if (wr_sys && mode_ok && reg_wdata_in[`LSGD_SYS_SLEEP_BIT])
            sleep_reg <= 1'b1;
         else if (cpu_irq_in)
            sleep_reg <= 1'b0;

         if (wr_hso)
         begin
            lamp_switch_force_on_reg <=
               reg_wdata_in[`LSGD_HSO_ON_LSB +: NUM_SWITCHES];
            lamp_switch_pwm_select_reg <=
               reg_wdata_in[`LSGD_HSO_PWM_LSB +: NUM_SWITCHES];
            aux_5v_out_on_reg <= reg_wdata_in[`LSGD_HSO_AUX_ON_BIT];
         end

         // fault set wins over the clear
         lamp_switch_overcurrent_flag_reg <= (lamp_switch_overcurrent_flag_reg & ~lamp_clear) |
                                             lamp_overcurrent_in;
         aux_5v_overcurrent_flag_reg <= (aux_5v_overcurrent_flag_reg & ~aux_clear) |
                                        aux_overcurrent_in;
         glass_short_flag_reg <= (glass_short_flag_reg & ~short_clear) |
                                 glass_short_in;
         glass_openload_flag_reg <= (glass_openload_flag_reg & ~olf_clear) |
                                    olf_event;

         if (wr_gc)
         begin
            glass_openload_test_reg <= reg_wdata_in[`LSGD_GC_OLT_BIT];
            // an open-load clear leaves both transistors off
            glass_regulator_enable_reg <= reg_wdata_in[`LSGD_GC_REG_EN_BIT] &
                                          ~reg_wdata_in[`LSGD_GC_OLF_BIT];
            glass_series_switch_enable_reg <= reg_wdata_in[`LSGD_GC_SER_EN_BIT] &
                                              ~reg_wdata_in[`LSGD_GC_OLF_BIT];
         end
         if (wr_code)
            glass_voltage_code_bits_reg <= reg_wdata_in[`LSGD_CODE_WIDTH-1:0];

         lamp_switch_on_out <= lamp_on_next;
         // limiting keeps the aux output on; voltage flags have no path here
         aux_5v_output_on_out <= power_stage_enable_reg & aux_5v_out_on_reg;
         power_stage_enable_out <= power_stage_enable_reg;
         glass_regulator_enable_out <= glass_regulator_enable_reg & glass_allowed;
         glass_series_switch_enable_out <= glass_series_switch_enable_reg &
                                           glass_allowed;
         glass_test_current_out <= glass_openload_test_reg;
         glass_voltage_code_out <= glass_voltage_code_bits_reg;
         stop_request_out <= stop_reg;
         sleep_request_out <= sleep_reg;
      end
   end

endmodule // lsgd_ctrl
`default_nettype wire

// >>> logic/lsgd_consts.vh
// register offsets, field positions and reset values of the lamp/glass control block
`ifndef LSGD_CONSTS_VH
`define LSGD_CONSTS_VH

`define LSGD_ADDR_SYSTEM_CONTROL 8'h00
`define LSGD_ADDR_HS_OUT_CTRL 8'h02
`define LSGD_ADDR_HS_FAULT 8'h04
`define LSGD_ADDR_GLASS_CTRL 8'h05
`define LSGD_ADDR_GLASS_CODE 8'h06

`define LSGD_SYS_POWER_STAGE_ENABLE_BIT 7
`define LSGD_SYS_STOP_BIT 1
`define LSGD_SYS_SLEEP_BIT 0

`define LSGD_HSO_ON_LSB 0
`define LSGD_HSO_PWM_LSB 3
`define LSGD_HSO_AUX_ON_BIT 6

`define LSGD_HSF_OCF_LSB 0
`define LSGD_HSF_AUX_OCF_BIT 3

`define LSGD_GC_REG_EN_BIT 7
`define LSGD_GC_OLT_BIT 6
`define LSGD_GC_SER_EN_BIT 5
`define LSGD_GC_SHORT_BIT 1
`define LSGD_GC_OLF_BIT 0

`define LSGD_CODE_WIDTH 6
`define LSGD_RESET_BYTE 8'h00

`endif

// >>> verif/lsgd_mcu.sv
// processor side model: pwm pin source
`timescale 1ns/1ns
`default_nettype none
module lsgd_mcu (
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic level_in,
   output logic pwm_out
);
   logic [2:0] cnt_reg = 3'h0;
   initial pwm_out = 1'b0;
   // free pwm, or a held level so inrush steps are exact
   always @(posedge clk_in)
   begin
      cnt_reg <= cnt_reg + 3'h1;
      pwm_out <= run_in ? cnt_reg[2] : level_in;
   end
endmodule // lsgd_mcu
`default_nettype wire

// >>> verif/lsgd_ctrl_chk.sv
// port assertions for the lamp/glass control block
`timescale 1ns/1ns
`default_nettype none
module lsgd_ctrl_chk #(
   parameter NUM_SWITCHES = 3
)(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic pwm_in,
   input wire logic cpu_irq_in,
   input wire logic [NUM_SWITCHES-1:0] lamp_overcurrent_in,
   input wire logic glass_short_in,
   input wire logic [NUM_SWITCHES-1:0] lamp_switch_on_out,
   input wire logic aux_5v_output_on_out,
   input wire logic power_stage_enable_out,
   input wire logic glass_regulator_enable_out,
   input wire logic glass_series_switch_enable_out,
   input wire logic [5:0] glass_voltage_code_out,
   input wire logic stop_request_out,
   input wire logic sleep_request_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   logic [7:0] hso_reg;
   // lamp mode bits are not visible at the ports, so shadow them
   always @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         hso_reg <= 8'h00;
      else if (reg_write_in && reg_addr_in == 8'h02)
         hso_reg <= reg_wdata_in;
   end
   a_lamp_trip_off: assert property (hso_reg[0] && !hso_reg[3] && lamp_overcurrent_in[0]
      && !reg_write_in |=> ##[0:1] !lamp_switch_on_out[0]) else $error("lamp trip");
   a_pwm_edge_on: assert property (!hso_reg[0] && hso_reg[3] && power_stage_enable_out
      && $rose(pwm_in) && !lamp_overcurrent_in[0] && !reg_write_in && !$past(reg_write_in)
      |=> lamp_switch_on_out[0]) else $error("pwm restart");
   a_both_stay_on: assert property (hso_reg[0] && hso_reg[3] && power_stage_enable_out
      && !reg_write_in && !$past(reg_write_in) |=> lamp_switch_on_out[0]) else $error("limit");
   a_lamps_need_ps: assert property (!power_stage_enable_out |-> lamp_switch_on_out == '0)
      else $error("lamp without ps");
   a_aux_need_ps: assert property (aux_5v_output_on_out |-> power_stage_enable_out)
      else $error("aux without ps");
   a_short_kills_glass: assert property (glass_short_in |-> ##2
      !glass_regulator_enable_out && !glass_series_switch_enable_out) else $error("short");
   a_stop_only_clean: assert property ($rose(stop_request_out) |-> $past(reg_write_in, 2)
      && $past(reg_addr_in, 2) == 8'h00 && $past(reg_wdata_in[7:2], 2) == 6'h00)
      else $error("stop");
   a_irq_clears_modes: assert property (cpu_irq_in && !reg_write_in |-> ##2
      !stop_request_out && !sleep_request_out) else $error("irq");
   a_code_follows: assert property (reg_write_in && reg_addr_in == 8'h06 |-> ##2
      glass_voltage_code_out == $past(reg_wdata_in[5:0], 2)) else $error("code");
   c_pwm_restart: cover property (hso_reg[3] && $rose(pwm_in));
   c_stop: cover property ($rose(stop_request_out));
   c_short: cover property (glass_short_in);
endmodule // lsgd_ctrl_chk
bind lsgd_ctrl lsgd_ctrl_chk #(.NUM_SWITCHES(NUM_SWITCHES)) u_chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .pwm_in(pwm_in),
   .cpu_irq_in(cpu_irq_in), .lamp_overcurrent_in(lamp_overcurrent_in),
   .glass_short_in(glass_short_in), .lamp_switch_on_out(lamp_switch_on_out),
   .aux_5v_output_on_out(aux_5v_output_on_out), .power_stage_enable_out(power_stage_enable_out),
   .glass_regulator_enable_out(glass_regulator_enable_out),
   .glass_series_switch_enable_out(glass_series_switch_enable_out),
   .glass_voltage_code_out(glass_voltage_code_out), .stop_request_out(stop_request_out),
   .sleep_request_out(sleep_request_out));
`default_nettype wire

// >>> verif/lsgd_ctrl_tb.sv
// self-checking bench for the lamp/glass control block
`timescale 1ns/1ns
`default_nettype none
module lsgd_ctrl_tb;
   logic clk_in = 1'b0, resetn_in = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq = 1'b0;
   logic aux_oc = 1'b0, short = 1'b0, cmp = 1'b0, run = 1'b0, level = 1'b0, pwm;
   logic aux, power_stage_enable, reg_en, ser_en, tcur, stop, sleep;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [2:0] oc = 3'h0, lamp;
   logic [5:0] code;
   logic [31:0] seed = 32'h448b;
   int bad_count = 0, checks = 0, cyc = 0;
   initial forever #20 clk_in = ~clk_in;
   lsgd_mcu u_mcu (.clk_in(clk_in), .run_in(run), .level_in(level), .pwm_out(pwm));
   lsgd_ctrl u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
      .pwm_in(pwm), .cpu_irq_in(irq), .lamp_overcurrent_in(oc), .aux_overcurrent_in(aux_oc),
      .glass_short_in(short), .glass_openload_cmp_in(cmp), .lamp_switch_on_out(lamp),
      .aux_5v_output_on_out(aux), .power_stage_enable_out(power_stage_enable),
      .glass_regulator_enable_out(reg_en), .glass_series_switch_enable_out(ser_en),
      .glass_test_current_out(tcur), .glass_voltage_code_out(code),
      .stop_request_out(stop), .sleep_request_out(sleep));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
      tick(3);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      tick(1);
      chk(rdata, exp);
   endtask
   // one-cycle pulse on the fault comparators and the irq line
   task automatic pulse(input logic [2:0] o, input logic a, s, c, i);
      @(posedge clk_in);
      {oc, aux_oc, short, cmp, irq} <= {o, a, s, c, i};
      @(posedge clk_in);
      {oc, aux_oc, short, cmp, irq} <= 7'h00;
      tick(3);
   endtask
   task automatic set_pwm(input logic v);
      @(posedge clk_in);
      level <= v;
      tick(4);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         bad_count++;
         complete_run;
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_in);
      resetn_in <= 1'b1;
      for (int i = 0; i < 7; i++) rd(i[7:0], 8'h00);
      repeat (8)
      begin
         seed = xs(seed);
         wr(8'h06, seed[7:0]);
         rd(8'h06, {2'b00, seed[5:0]});
         chk({2'b00, code}, {2'b00, seed[5:0]});
      end
      $display("test registers done");
      wr(8'h00, 8'h80);
      wr(8'h02, 8'h07);
      chk({5'h0, lamp}, 8'h07);
      pulse(3'h2, 0, 0, 0, 0);
      chk({5'h0, lamp}, 8'h05);
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h02);
      wr(8'h04, 8'h02);
      chk({5'h0, lamp}, 8'h07);
      wr(8'h02, 8'h08);
      set_pwm(1);
      chk({5'h0, lamp}, 8'h01);
      pulse(3'h1, 0, 0, 0, 0);
      chk({5'h0, lamp}, 8'h00);
      set_pwm(0);
      set_pwm(1);
      set_pwm(0);
      chk({5'h0, lamp}, 8'h01);
      pulse(3'h1, 0, 0, 0, 0);
      chk({5'h0, lamp}, 8'h00);
      wr(8'h02, 8'h09);
      pulse(3'h1, 0, 0, 0, 0);
      chk({5'h0, lamp}, 8'h01);
      rd(8'h04, 8'h01);
      wr(8'h00, 8'h00);
      chk({5'h0, lamp}, 8'h00);
      chk({7'h0, power_stage_enable}, 8'h00);
      $display("test lamps done");
      wr(8'h00, 8'h80);
      chk({7'h0, power_stage_enable}, 8'h01);
      wr(8'h02, 8'h40);
      pulse(3'h0, 1, 0, 0, 0);
      chk({7'h0, aux}, 8'h01);
      rd(8'h04, 8'h09);
      wr(8'h04, 8'h08);
      rd(8'h04, 8'h01);
      wr(8'h00, 8'h00);
      chk({7'h0, aux}, 8'h00);
      wr(8'h05, 8'ha0);
      chk({6'h0, reg_en, ser_en}, 8'h03);
      pulse(3'h0, 0, 1, 0, 0);
      chk({6'h0, reg_en, ser_en}, 8'h00);
      rd(8'h05, 8'ha2);
      wr(8'h05, 8'ha2);
      chk({6'h0, reg_en, ser_en}, 8'h03);
      wr(8'h05, 8'he0);
      chk({5'h0, tcur, reg_en, ser_en}, 8'h04);
      pulse(3'h0, 0, 0, 1, 0);
      rd(8'h05, 8'he1);
      wr(8'h05, 8'he1);
      rd(8'h05, 8'h40);
      $display("test aux and glass done");
      wr(8'h00, 8'h02);
      chk({6'h0, stop, sleep}, 8'h02);
      pulse(3'h0, 0, 0, 0, 1);
      chk({6'h0, stop, sleep}, 8'h00);
      wr(8'h00, 8'h06);
      wr(8'h00, 8'h81);
      chk({6'h0, stop, sleep}, 8'h00);
      wr(8'h00, 8'h01);
      chk({6'h0, stop, sleep}, 8'h01);
      pulse(3'h0, 0, 0, 0, 1);
      // free-running pwm with random trips, judged by the checker
      run <= 1'b1;
      wr(8'h00, 8'h80);
      wr(8'h02, 8'h2e);
      repeat (30)
      begin
         seed = xs(seed);
         pulse(seed[2:0], seed[3], seed[4], 1'b0, 1'b0);
      end
      $display("test modes and random done");
      complete_run;
   end
endmodule // lsgd_ctrl_tb
`default_nettype wire
